// ---- core/tws_defs.svh ----
`ifndef TWS_DEFS_SVH
`define TWS_DEFS_SVH

`define TWS_BYTE_BITS 4'h8
`define TWS_BIT_LAST 4'h7
`define TWS_ACK_SLOT 4'h8
`define TWS_DEV_ADDR_RESET 7'h5d
`define TWS_PTR_RESET 8'h00
`define TWS_WORD_RESET 16'h0000
`define TWS_IDLE_RUN 4'h7

`endif

// ---- core/tws_pkg.sv ----
package tws_pkg;
    typedef enum logic [2:0] {
        TWS_IDLE,
        TWS_ADDR,
        TWS_PTR,
        TWS_WDATA,
        TWS_RDATA,
        TWS_SKIP
    } tws_state_t;

    typedef logic [15:0] tws_word_t;
endpackage

// ---- core/tws_req_xfer.sv ----
module tws_req_xfer (
    // Source domain
    input wire logic src_clk,
    input wire logic src_rst_n,
    input wire logic src_pulse,
    input wire logic [23:0] src_data,
    // Destination domain
    input wire logic dst_clk,
    input wire logic dst_rst_n,
    output logic dst_pulse,
    output logic [23:0] dst_data
);
    logic toggle;
    logic [23:0] hold;
    logic sync1;
    logic sync2;
    logic sync3;

    // Data is held stable long before the toggle lands, so no word sync is needed
    always_ff @(posedge src_clk or negedge src_rst_n) begin
        if (!src_rst_n) begin
            toggle <= 1'b0;
            hold <= 24'h000000;
        end else if (src_pulse) begin
            toggle <= ~toggle;
            hold <= src_data;
        end
    end

    always_ff @(posedge dst_clk or negedge dst_rst_n) begin
        if (!dst_rst_n) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
            dst_pulse <= 1'b0;
            dst_data <= 24'h000000;
        end else begin
            sync1 <= toggle;
            sync2 <= sync1;
            sync3 <= sync2;
            dst_pulse <= sync2 ^ sync3;
            if (sync2 ^ sync3) begin
                dst_data <= hold;
            end
        end
    end
endmodule

// ---- core/tws_slave.sv ----
`include "tws_defs.svh"

module tws_slave #(
    parameter logic [6:0] DEV_ADDR = `TWS_DEV_ADDR_RESET
) (
    // Core clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Serial link, clocked by the master's serial clock
    input wire logic link_clk,
    input wire logic two_wire_data_pin_in,
    output logic two_wire_data_pin_out,
    output logic two_wire_data_pin_oe_n,
    // Register store write port
    output logic reg_wr,
    output logic [7:0] reg_wr_addr,
    output tws_pkg::tws_word_t reg_wr_data,
    // Register store read port
    output logic [7:0] reg_rd_addr,
    input wire tws_pkg::tws_word_t reg_rd_data,
    // Status
    output logic bus_busy
);
    import tws_pkg::*;

    tws_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shift_in;
    logic [7:0] ptr;
    logic hi_byte;
    logic [7:0] hi_hold;
    logic wr_pulse;
    logic [23:0] wr_req;
    logic [15:0] tx_word;
    logic drive_low;
    logic link_rst_n;
    logic start_seen;
    logic start_tog;
    logic stop_tog;
    logic active;
    logic start_q;
    logic stop_q;
    logic [7:0] fetch_ptr;
    logic [3:0] idle_cnt;
    logic [15:0] rd_sync2;
    logic [7:0] ptr_sync1;
    logic [7:0] ptr_sync2;
    logic sda_core;
    logic link_core;
    logic core_wr;
    logic [23:0] core_wr_req;

    // start is a fall of data while the clock is high
    // detected only, the data edge itself clocks the flag
    always_ff @(negedge two_wire_data_pin_in or negedge reset_n) begin
        if (!reset_n) begin
            start_tog <= 1'b0;
        end else if (link_clk) begin
            start_tog <= ~start_tog;
        end
    end

    // stop is a rise of data while the clock is high
    always_ff @(posedge two_wire_data_pin_in or negedge reset_n) begin
        if (!reset_n) begin
            stop_tog <= 1'b0;
        end else if (link_clk) begin
            stop_tog <= ~stop_tog;
        end
    end

    // Start/stop toggles are sampled on the next rising serial clock
    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            start_q <= 1'b0;
        end else begin
            start_q <= start_tog;
        end
    end

    assign start_seen = start_q != start_tog;

    // stop leaves the link idle until a fresh start
    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            stop_q <= 1'b0;
        end else begin
            stop_q <= stop_tog;
        end
    end

    assign active = (stop_q == stop_tog) || start_seen;
    assign link_rst_n = reset_n;

    // Bit counter: 0..7 data, 8 acknowledge slot
    // one bit per rising serial clock edge
    // eight data bits then the ninth ack pulse
    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            bit_cnt <= 4'h0;
        end else if (start_seen || !active) begin
            bit_cnt <= start_seen ? 4'h1 : 4'h0;
        end else if (bit_cnt == `TWS_ACK_SLOT) begin
            bit_cnt <= 4'h0;
        end else begin
            bit_cnt <= bit_cnt + 4'h1;
        end
    end

    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            shift_in <= 8'h00;
        end else if (start_seen) begin
            shift_in <= {7'h00, two_wire_data_pin_in};
        end else if (bit_cnt < `TWS_BYTE_BITS) begin
            shift_in <= {shift_in[6:0], two_wire_data_pin_in};
        end
    end

    // Byte-level state machine, advanced at the end of each byte
    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            state <= TWS_IDLE;
        end else if (start_seen) begin
            state <= TWS_ADDR;
        end else if (!active) begin
            state <= TWS_IDLE;
        end else if (bit_cnt == `TWS_ACK_SLOT) begin
            case (state)
                TWS_ADDR: begin
                    // foreign addresses are ignored to the next start
                    if (shift_in[7:1] != DEV_ADDR) begin
                        state <= TWS_SKIP;
                    end else if (shift_in[0]) begin
                        state <= TWS_RDATA;
                    end else begin
                        state <= TWS_PTR;
                    end
                end
                TWS_PTR: begin
                    state <= TWS_WDATA;
                end
                TWS_RDATA: begin
                    // high data in the ack slot is a no-ack
                    if (two_wire_data_pin_in) begin
                        state <= TWS_SKIP;
                    end
                end
                default: begin
                    state <= state;
                end
            endcase
        end
    end

    // Pointer, byte phase and word assembly
    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            ptr <= `TWS_PTR_RESET;
            fetch_ptr <= `TWS_PTR_RESET;
            hi_byte <= 1'b1;
            hi_hold <= 8'h00;
            wr_pulse <= 1'b0;
            wr_req <= 24'h000000;
        end else begin
            wr_pulse <= 1'b0;
            if (start_seen) begin
                hi_byte <= 1'b1;
            end else if (active && bit_cnt == `TWS_ACK_SLOT) begin
                if (state == TWS_PTR) begin
                    ptr <= shift_in;
                    fetch_ptr <= shift_in;
                    hi_byte <= 1'b1;
                end else if (state == TWS_WDATA) begin
                    if (hi_byte) begin
                        hi_hold <= shift_in;
                    end else begin
                        // commit only with the full word
                        wr_pulse <= 1'b1;
                        wr_req <= {ptr, hi_hold, shift_in};
                        ptr <= ptr + 8'h01;
                        fetch_ptr <= ptr + 8'h01;
                    end
                    hi_byte <= ~hi_byte;
                end else if (state == TWS_RDATA) begin
                    if (!hi_byte) begin
                        ptr <= ptr + 8'h01;
                    end else begin
                        // Fetch the next word a byte early, the crossing needs time
                        fetch_ptr <= ptr + 8'h01;
                    end
                    hi_byte <= ~hi_byte;
                end
            end
        end
    end

    // Read word comes from the core domain; the pointer is stable for a whole
    // byte, well beyond three core cycles plus the store access.
    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            rd_sync2 <= `TWS_WORD_RESET;
        end else begin
            rd_sync2 <= reg_rd_data;
        end
    end

    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            tx_word <= `TWS_WORD_RESET;
        end else if (bit_cnt == `TWS_ACK_SLOT) begin
            // Reloaded at every ack; the low byte ack picks up the prefetched word
            tx_word <= rd_sync2;
        end
    end

    // Drive decision made on the falling edge so data changes only while
    // the serial clock is low.
    // transmitter changes data with the clock low
    // ack by pulling low; release when transmitting ack
    always_ff @(negedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            drive_low <= 1'b0;
        end else if (!active || start_seen) begin
            drive_low <= 1'b0;
        end else if (bit_cnt == `TWS_ACK_SLOT) begin
            case (state)
                TWS_ADDR: drive_low <= shift_in[7:1] == DEV_ADDR;
                TWS_PTR, TWS_WDATA: drive_low <= 1'b1;
                default: drive_low <= 1'b0;
            endcase
        end else if (state == TWS_RDATA && bit_cnt < `TWS_BYTE_BITS) begin
            drive_low <= hi_byte ? ~tx_word[4'hf - bit_cnt]
                                 : ~tx_word[4'h7 - bit_cnt];
        end else begin
            drive_low <= 1'b0;
        end
    end

    // open drain, output always low, enable low drives
    assign two_wire_data_pin_out = 1'b0;
    assign two_wire_data_pin_oe_n = ~drive_low;

    // Core side: write requests cross by toggle handshake
    tws_req_xfer u_xfer (
        .src_clk(link_clk),
        .src_rst_n(link_rst_n),
        .src_pulse(wr_pulse),
        .src_data(wr_req),
        .dst_clk(core_clk),
        .dst_rst_n(reset_n),
        .dst_pulse(core_wr),
        .dst_data(core_wr_req)
    );

    tws_sync u_sda_sync (
        .clk(core_clk),
        .rst_n(reset_n),
        .din(two_wire_data_pin_in),
        .dout(sda_core)
    );

    tws_sync u_clk_sync (
        .clk(core_clk),
        .rst_n(reset_n),
        .din(link_clk),
        .dout(link_core)
    );

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_wr <= 1'b0;
            reg_wr_addr <= 8'h00;
            reg_wr_data <= `TWS_WORD_RESET;
        end else begin
            reg_wr <= core_wr;
            if (core_wr) begin
                reg_wr_addr <= core_wr_req[23:16];
                reg_wr_data <= core_wr_req[15:0];
            end
        end
    end

    // Pointer is quasi-static during a byte, two stages settle it
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ptr_sync1 <= 8'h00;
            ptr_sync2 <= 8'h00;
            reg_rd_addr <= 8'h00;
        end else begin
            ptr_sync1 <= fetch_ptr;
            ptr_sync2 <= ptr_sync1;
            reg_rd_addr <= ptr_sync2;
        end
    end

    // idle seen when both lines are high
    // A run of samples is needed: a single one may land in a data bit's high clock
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_busy <= 1'b0;
            idle_cnt <= 4'h0;
        end else if (sda_core && link_core) begin
            if (idle_cnt == `TWS_IDLE_RUN) begin
                bus_busy <= 1'b0;
            end else begin
                idle_cnt <= idle_cnt + 4'h1;
            end
        end else begin
            idle_cnt <= 4'h0;
            bus_busy <= 1'b1;
        end
    end
endmodule

// ---- core/tws_sync.sv ----
module tws_sync (
    // Clock and reset of the receiving domain
    input wire logic clk,
    input wire logic rst_n,
    // Level to be brought in
    input wire logic din,
    output logic dout
);
    logic stage1;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= 1'b1;
            dout <= 1'b1;
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule

// ---- dv/test_two_wire_register_slave.sv ----
module test_two_wire_register_slave;
    timeunit 1ns;
    timeprecision 1ps;
    import tws_pkg::*;
    logic core_clk, reset_n, link_clk, pull_low, pin_out, pin_oe_n, reg_wr, bus_busy, ack;
    logic [7:0] reg_wr_addr, reg_rd_addr, rx, hi, lo;
    tws_word_t reg_wr_data, regs [256];
    int num_errors = 0, tests_run = 0, wr_count = 0, n;
    wire logic line = (pull_low || (!pin_oe_n && !pin_out)) ? 1'b0 : 1'b1;
    tws_slave dut_u (.core_clk(core_clk), .reset_n(reset_n), .link_clk(link_clk),
        .two_wire_data_pin_in(line), .two_wire_data_pin_out(pin_out),
        .two_wire_data_pin_oe_n(pin_oe_n), .reg_wr(reg_wr), .reg_wr_addr(reg_wr_addr),
        .reg_wr_data(reg_wr_data), .reg_rd_addr(reg_rd_addr),
        .reg_rd_data(regs[reg_rd_addr]), .bus_busy(bus_busy));
    tws_master_model master_u (.link_clk(link_clk), .pull_low(pull_low), .line(line));
    always @(posedge core_clk)
        if (reg_wr) begin
            regs[reg_wr_addr] <= reg_wr_data;
            wr_count++;
        end
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic check(input string what, input tws_word_t exp, input tws_word_t got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wb(input logic [7:0] b, input logic exp_ack);
        master_u.xfer(b, 1'b1, rx, ack);
        check("ack", {15'h0, exp_ack}, {15'h0, ack});
    endtask
    task automatic wr_head(input logic [7:0] ptr);
        master_u.start();
        wb(8'hba, 1'b1);
        wb(ptr, 1'b1);
    endtask
    task automatic finish_wr();
        master_u.stop();
        repeat (20) @(posedge core_clk);
    endtask
    task automatic t_write();
        n = wr_count;
        wr_head(8'h20);
        wb(8'h12, 1'b1);
        wb(8'h34, 1'b1);
        wb(8'hab, 1'b1);
        wb(8'hcd, 1'b1);
        finish_wr();
        check("writes", 16'(n + 2), 16'(wr_count));
        check("reg20", 16'h1234, regs[8'h20]);
        check("reg21", 16'habcd, regs[8'h21]);
    endtask
    task automatic t_read();
        wr_head(8'h20);
        master_u.start();
        wb(8'hbb, 1'b1);
        master_u.xfer(8'hff, 1'b0, hi, ack);
        master_u.xfer(8'hff, 1'b0, lo, ack);
        check("rd20", 16'h1234, {hi, lo});
        master_u.xfer(8'hff, 1'b0, hi, ack);
        master_u.xfer(8'hff, 1'b1, lo, ack);
        check("rd21", 16'habcd, {hi, lo});
        check("released", 16'h0001, {15'h0, line});
        finish_wr();
    endtask
    task automatic t_other();
        n = wr_count;
        master_u.gap_ns = 0;
        master_u.start();
        wb(8'h54, 1'b0);
        wb(8'h50, 1'b0);
        wb(8'h11, 1'b0);
        wb(8'h22, 1'b0);
        master_u.gap_ns = 300;
        finish_wr();
        check("writes", 16'(n), 16'(wr_count));
        check("reg50", 16'h5050, regs[8'h50]);
    endtask
    task automatic t_partial();
        n = wr_count;
        wr_head(8'h30);
        wb(8'h99, 1'b1);
        finish_wr();
        check("writes", 16'(n), 16'(wr_count));
        check("reg30", 16'h3030, regs[8'h30]);
    endtask
    task automatic t_restart();
        n = wr_count;
        wr_head(8'h40);
        wb(8'h77, 1'b1);
        wr_head(8'h41);
        wb(8'h56, 1'b1);
        wb(8'h78, 1'b1);
        finish_wr();
        check("writes", 16'(n + 1), 16'(wr_count));
        check("reg41", 16'h5678, regs[8'h41]);
        check("reg40", 16'h4040, regs[8'h40]);
    endtask
    task automatic print_verdict();
        if (num_errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        for (int i = 0; i < 256; i++)
            regs[i] = {8'(i), 8'(i)};
        reset_n = 1'b0;
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        t_write();
        t_read();
        t_other();
        t_partial();
        t_restart();
        print_verdict();
    end
    // Whole run is near 13 us
    initial begin
        #200us;
        num_errors++;
        print_verdict();
    end
endmodule
bind tws_slave tws_slave_asserts chk_u (.core_clk(core_clk), .reset_n(reset_n),
    .link_clk(link_clk), .two_wire_data_pin_in(two_wire_data_pin_in),
    .two_wire_data_pin_out(two_wire_data_pin_out),
    .two_wire_data_pin_oe_n(two_wire_data_pin_oe_n), .reg_wr(reg_wr),
    .reg_wr_addr(reg_wr_addr), .bus_busy(bus_busy));

// ---- dv/tws_master_model.sv ----
module tws_master_model (
    // Serial side
    output logic link_clk,
    output logic pull_low,
    input wire logic line
);
    timeunit 1ns;
    timeprecision 1ps;
    int gap_ns = 300;
    initial begin
        link_clk = 1'b1;
        pull_low = 1'b0;
    end
    task automatic start();
        link_clk = 1'b0;
        #3 pull_low = 1'b0;
        #3 link_clk = 1'b1;
        #3 pull_low = 1'b1;
        #3 link_clk = 1'b0;
    endtask
    task automatic stop();
        #3 pull_low = 1'b1;
        #3 link_clk = 1'b1;
        #3 pull_low = 1'b0;
        #6;
    endtask
    task automatic clk_bit(input logic v, output logic s);
        #3 pull_low = !v;
        #3 link_clk = 1'b1;
        #1 s = line;
        #5 link_clk = 1'b0;
    endtask
    task automatic xfer(input logic [7:0] tx, input logic ack_v, output logic [7:0] rx,
                        output logic acked);
        logic s;
        for (int i = 7; i >= 0; i--)
            clk_bit(tx[i], rx[i]);
        clk_bit(ack_v, s);
        acked = !s;
        #3 pull_low = 1'b0;
        // Clock held low gives the slave time to cross domains
        #(gap_ns);
    endtask
endmodule

// ---- dv/tws_slave_asserts.sv ----
module tws_slave_asserts (
    // Clocks and reset
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic link_clk,
    // Serial pin
    input wire logic two_wire_data_pin_in,
    input wire logic two_wire_data_pin_out,
    input wire logic two_wire_data_pin_oe_n,
    // Store port and status
    input wire logic reg_wr,
    input wire logic [7:0] reg_wr_addr,
    input wire logic bus_busy
);
    logic [3:0] low_run;
    logic [7:0] prev_addr;
    logic have_prev;
    // An ack followed by a zero data byte keeps the pin low for nine bits
    always_ff @(posedge link_clk or negedge reset_n)
        if (!reset_n)
            low_run <= 4'h0;
        else
            low_run <= two_wire_data_pin_oe_n ? 4'h0 : low_run + 4'h1;
    always_ff @(posedge core_clk or negedge reset_n)
        if (!reset_n)
            have_prev <= 1'b0;
        else
            have_prev <= bus_busy && (have_prev || reg_wr);
    always_ff @(posedge core_clk or negedge reset_n)
        if (!reset_n)
            prev_addr <= 8'h00;
        else if (reg_wr)
            prev_addr <= reg_wr_addr;
    property p_out_zero;
        @(posedge core_clk) disable iff (!reset_n) two_wire_data_pin_out == 1'b0;
    endproperty
    a_out_zero: assert property (p_out_zero) else $error("pin output not low");
    property p_drive_low;
        @(posedge link_clk) disable iff (!reset_n) !two_wire_data_pin_oe_n |-> !two_wire_data_pin_in;
    endproperty
    a_drive_low: assert property (p_drive_low) else $error("driven pin not low");
    property p_low_run;
        @(posedge link_clk) disable iff (!reset_n) low_run <= 4'h9;
    endproperty
    a_low_run: assert property (p_low_run) else $error("pin held low too long");
    property p_wr_pulse;
        @(posedge core_clk) disable iff (!reset_n) reg_wr |=> !reg_wr;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse too long");
    property p_wr_inc;
        @(posedge core_clk) disable iff (!reset_n)
            reg_wr && have_prev |-> reg_wr_addr == prev_addr + 8'h01;
    endproperty
    a_wr_inc: assert property (p_wr_inc) else $error("write pointer not stepped");
    property p_idle_rel;
        @(posedge core_clk) disable iff (!reset_n)
            (link_clk && two_wire_data_pin_in) [*8] |-> two_wire_data_pin_oe_n;
    endproperty
    a_idle_rel: assert property (p_idle_rel) else $error("pin driven on idle bus");
    property p_busy_idle;
        @(posedge core_clk) disable iff (!reset_n)
            (link_clk && two_wire_data_pin_in) [*8] |-> ##[0:4] !bus_busy;
    endproperty
    a_busy_idle: assert property (p_busy_idle) else $error("busy after stop");
    property p_free_rel;
        @(posedge core_clk) disable iff (!reset_n) !bus_busy |-> two_wire_data_pin_oe_n;
    endproperty
    a_free_rel: assert property (p_free_rel) else $error("pin driven while free");
    c_write: cover property (@(posedge core_clk) disable iff (!reset_n) reg_wr);
    c_drive: cover property (@(posedge link_clk) disable iff (!reset_n) low_run == 4'h9);
    c_busy: cover property (@(posedge core_clk) disable iff (!reset_n) $fell(bus_busy));
endmodule
